// >>> dbsa_pkg.sv
// Constants, target codes and carrier structs for the dual-bank memory arbiter.
package dbsa_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths of the closely coupled port signals.
    localparam int AW     = 32;
    localparam int DW     = 32;
    localparam int BEW    = 4;
    localparam int MEM_AW = 17;     // Wide enough for the largest bank offset.

    // Address map in the 32-bit internal space.
    localparam logic [31:0] ROM_BASE  = 32'h0000_0000;
    localparam logic [31:0] ROM_SIZE  = 32'h0000_8000;   // 32 KB boot ROM.
    localparam logic [31:0] SRAM_BASE = 32'h0010_0000;
    localparam logic [31:0] B0_SIZE   = 32'h0001_8000;   // 96 KB fetch-favoured bank.
    localparam logic [31:0] B1_SIZE   = 32'h0000_8000;   // 32 KB data-favoured bank.

    // Target indices and the port that each target favours on a conflict.
    localparam int         NT       = 3;
    localparam int         T_ROM    = 0;
    localparam int         T_B0     = 1;
    localparam int         T_B1     = 2;
    localparam logic [2:0] FAV_DATA = 3'b100;   // Bit set: data port is favoured.

    // Pipeline depth from grant to response.
    localparam int RSP_LAT = 2;

    ////////////////////////////////////////////////////////////////////////////////
    typedef enum logic [3:0] {
        DBSA_TGT_NONE = 4'b0001,
        DBSA_TGT_ROM  = 4'b0010,
        DBSA_TGT_B0   = 4'b0100,
        DBSA_TGT_B1   = 4'b1000
    } dbsa_tgt_t;

    typedef struct packed {
        logic           req;
        logic           we;
        logic [BEW-1:0] be;
        logic [AW-1:0]  addr;
        logic [DW-1:0]  wdata;
    } dbsa_req_t;

    typedef struct packed {
        logic          rvalid;
        logic          err;
        logic [DW-1:0] rdata;
    } dbsa_rsp_t;

    typedef struct packed {
        logic              en;
        logic              we;
        logic [BEW-1:0]    be;
        logic [MEM_AW-1:0] addr;
        logic [DW-1:0]     wdata;
    } dbsa_mem_t;

endpackage : dbsa_pkg

// >>> dbsa_arbiter.sv
// Decode and arbitration of the fetch and data ports onto two SRAM banks and the boot ROM.
`timescale 1ns/1ps
`default_nettype none

module dbsa_arbiter (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire dbsa_pkg::dbsa_req_t fetch_req,
    input  wire dbsa_pkg::dbsa_req_t data_req,
    output logic                    fetch_gnt,
    output logic                    data_gnt,
    output dbsa_pkg::dbsa_rsp_t     fetch_rsp,
    output dbsa_pkg::dbsa_rsp_t     data_rsp,
    output dbsa_pkg::dbsa_mem_t     rom_cmd,
    output dbsa_pkg::dbsa_mem_t     bank0_cmd,
    output dbsa_pkg::dbsa_mem_t     bank1_cmd,
    input  wire logic [31:0]        rom_rdata,
    input  wire logic [31:0]        bank0_rdata,
    input  wire logic [31:0]        bank1_rdata
);

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode, shared by both ports.
    function automatic dbsa_pkg::dbsa_tgt_t decode(input logic [31:0] a);
        logic [31:0] off;
        off = a - dbsa_pkg::SRAM_BASE;
        if (a - dbsa_pkg::ROM_BASE < dbsa_pkg::ROM_SIZE)
            return dbsa_pkg::DBSA_TGT_ROM;
        else if (off < dbsa_pkg::B0_SIZE)
            return dbsa_pkg::DBSA_TGT_B0;
        else if (off - dbsa_pkg::B0_SIZE < dbsa_pkg::B1_SIZE)
            return dbsa_pkg::DBSA_TGT_B1;
        else
            return dbsa_pkg::DBSA_TGT_NONE;
    endfunction : decode

    // Byte offset of an address inside the region that it decodes to.
    function automatic logic [16:0] region_off(input logic [31:0] a);
        logic [31:0] off;
        off = a - dbsa_pkg::SRAM_BASE;
        unique case (decode(a))
            dbsa_pkg::DBSA_TGT_ROM: return 17'(a - dbsa_pkg::ROM_BASE);
            dbsa_pkg::DBSA_TGT_B0:  return 17'(off);
            dbsa_pkg::DBSA_TGT_B1:  return 17'(off - dbsa_pkg::B0_SIZE);
            dbsa_pkg::DBSA_TGT_NONE: return 17'h0_0000;
        endcase
    endfunction : region_off

    ////////////////////////////////////////////////////////////////////////////////
    dbsa_pkg::dbsa_tgt_t tgt_f;
    dbsa_pkg::dbsa_tgt_t tgt_d;
    logic [2:0]          hit_f;
    logic [2:0]          hit_d;
    logic [2:0]          conflict;
    logic [2:0]          dwin;
    logic [2:0]          gnt_f_t;
    logic [2:0]          gnt_d_t;
    logic                miss_f;
    logic                miss_d;
    logic [2:0]          owed_vld_q;
    logic [2:0]          owed_data_q;   // Set: the data port is owed the target.

    // Which target each port wants this cycle; bit order follows the target indices.
    always_comb begin
        tgt_f  = decode(fetch_req.addr);
        tgt_d  = decode(data_req.addr);
        hit_f  = {3{fetch_req.req}} & tgt_f[3:1];
        hit_d  = {3{data_req.req}} & tgt_d[3:1];
        miss_f = fetch_req.req & (tgt_f == dbsa_pkg::DBSA_TGT_NONE);
        miss_d = data_req.req & (tgt_d == dbsa_pkg::DBSA_TGT_NONE);
    end

    // A conflict goes to the owed port if any, else to the favoured one.
    always_comb begin
        for (int t = 0; t < dbsa_pkg::NT; t++) begin
            conflict[t] = hit_f[t] & hit_d[t];
            dwin[t]     = owed_vld_q[t] ? owed_data_q[t] : dbsa_pkg::FAV_DATA[t];
            gnt_f_t[t]  = hit_f[t] & ~(conflict[t] & dwin[t]);
            gnt_d_t[t]  = hit_d[t] & ~(conflict[t] & ~dwin[t]);
        end
    end

    // Unmapped addresses are granted at once and answered with an error.
    assign fetch_gnt = (|gnt_f_t) | miss_f;
    assign data_gnt  = (|gnt_d_t) | miss_d;

    // The loser of a conflict is remembered for one turn; with no conflict the
    // debt is settled, since the loser either got the bank or withdrew.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            owed_vld_q  <= 3'h0;
            owed_data_q <= 3'h0;
        end else begin
            owed_vld_q  <= conflict;
            owed_data_q <= ~dwin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bank commands are combinational so a granted access reaches its bank with no wait.
    function automatic dbsa_pkg::dbsa_mem_t mk_cmd(input logic gf, input logic gd,
                                                   input dbsa_pkg::dbsa_req_t f,
                                                   input dbsa_pkg::dbsa_req_t d);
        dbsa_pkg::dbsa_req_t r;
        r = gf ? f : d;
        return '{en: gf | gd, we: r.we, be: r.be, addr: region_off(r.addr), wdata: r.wdata};
    endfunction : mk_cmd

    assign rom_cmd   = mk_cmd(gnt_f_t[0], gnt_d_t[0], fetch_req, data_req);
    assign bank0_cmd = mk_cmd(gnt_f_t[1], gnt_d_t[1], fetch_req, data_req);
    assign bank1_cmd = mk_cmd(gnt_f_t[2], gnt_d_t[2], fetch_req, data_req);

    ////////////////////////////////////////////////////////////////////////////////
    // Response pipeline: the memories answer one cycle after the command, and the
    // read data is registered once more so the port sees clean flop outputs.
    logic [1:0] s1_vld_q;
    logic [1:0] s1_err_q;
    logic [2:0] s1_sel_q [2];

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_vld_q    <= 2'h0;
            s1_err_q    <= 2'h0;
            s1_sel_q[0] <= 3'h0;
            s1_sel_q[1] <= 3'h0;
        end else begin
            s1_vld_q    <= {data_gnt, fetch_gnt};
            s1_err_q    <= {miss_d, miss_f};
            s1_sel_q[0] <= gnt_f_t;
            s1_sel_q[1] <= gnt_d_t;
        end
    end

    function automatic logic [31:0] pick(input logic [2:0] s, input logic [31:0] r0,
                                         input logic [31:0] r1, input logic [31:0] r2);
        return ({32{s[0]}} & r0) | ({32{s[1]}} & r1) | ({32{s[2]}} & r2);
    endfunction : pick

    always_ff @(posedge clk) begin
        if (!nrst) begin
            fetch_rsp <= '0;
            data_rsp  <= '0;
        end else begin
            fetch_rsp <= '{rvalid: s1_vld_q[0], err: s1_err_q[0],
                           rdata: pick(s1_sel_q[0], rom_rdata, bank0_rdata, bank1_rdata)};
            data_rsp  <= '{rvalid: s1_vld_q[1], err: s1_err_q[1],
                           rdata: pick(s1_sel_q[1], rom_rdata, bank0_rdata, bank1_rdata)};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on grant, decode and response timing.
    property p_split_no_wait;
        @(posedge clk) disable iff (!nrst)
        ((hit_f[dbsa_pkg::T_B0] && hit_d[dbsa_pkg::T_B1]) ||
         (hit_f[dbsa_pkg::T_B1] && hit_d[dbsa_pkg::T_B0])) |-> (fetch_gnt && data_gnt);
    endproperty
    a_split_no_wait: assert property (p_split_no_wait) else $error("split access stalled");

    property p_b0_fetch_first;
        @(posedge clk) disable iff (!nrst)
        (conflict[dbsa_pkg::T_B0] && !owed_vld_q[dbsa_pkg::T_B0]) |-> (fetch_gnt && !data_gnt);
    endproperty
    a_b0_fetch_first: assert property (p_b0_fetch_first) else $error("bank0 priority wrong");

    property p_b1_data_first;
        @(posedge clk) disable iff (!nrst)
        (conflict[dbsa_pkg::T_B1] && !owed_vld_q[dbsa_pkg::T_B1]) |-> (data_gnt && !fetch_gnt);
    endproperty
    a_b1_data_first: assert property (p_b1_data_first) else $error("bank1 priority wrong");

    property p_data_not_starved;
        @(posedge clk) disable iff (!nrst)
        (hit_d[dbsa_pkg::T_B0] && !data_gnt) ##1 hit_d[dbsa_pkg::T_B0] |-> data_gnt;
    endproperty
    a_data_not_starved: assert property (p_data_not_starved) else $error("data starved");

    property p_fetch_not_starved;
        @(posedge clk) disable iff (!nrst)
        (hit_f[dbsa_pkg::T_B1] && !fetch_gnt) ##1 hit_f[dbsa_pkg::T_B1] |-> fetch_gnt;
    endproperty
    a_fetch_not_starved: assert property (p_fetch_not_starved) else $error("fetch starved");

    property p_sram_base;
        @(posedge clk) disable iff (!nrst)
        (data_req.req && data_req.addr == dbsa_pkg::SRAM_BASE && !fetch_req.req)
            |-> (bank0_cmd.en && bank0_cmd.addr == 17'h0_0000 && !bank1_cmd.en);
    endproperty
    a_sram_base: assert property (p_sram_base) else $error("sram base decode wrong");

    property p_bank1_start;
        @(posedge clk) disable iff (!nrst)
        (fetch_req.req && fetch_req.addr == 32'h0011_8000 && !data_req.req)
            |-> (bank1_cmd.en && bank1_cmd.addr == 17'h0_0000 && !bank0_cmd.en);
    endproperty
    a_bank1_start: assert property (p_bank1_start) else $error("bank1 placement wrong");

    property p_rom_decode;
        @(posedge clk) disable iff (!nrst)
        (fetch_req.req && fetch_req.addr == 32'h0000_7ffc && !data_req.req)
            |-> (rom_cmd.en && rom_cmd.addr == 17'h0_7ffc);
    endproperty
    a_rom_decode: assert property (p_rom_decode) else $error("rom decode wrong");

    property p_rsp_latency;
        @(posedge clk) disable iff (!nrst)
        data_gnt |-> ##2 data_rsp.rvalid;
    endproperty
    a_rsp_latency: assert property (p_rsp_latency) else $error("response latency wrong");

    c_b0_conflict:  cover property (@(posedge clk) disable iff (!nrst)
                                    conflict[dbsa_pkg::T_B0] ##1 data_gnt);
    c_b1_conflict:  cover property (@(posedge clk) disable iff (!nrst)
                                    conflict[dbsa_pkg::T_B1] ##1 fetch_gnt);
    c_split:        cover property (@(posedge clk) disable iff (!nrst)
                                    gnt_f_t[dbsa_pkg::T_B1] && gnt_d_t[dbsa_pkg::T_B0]);
    c_unmapped:     cover property (@(posedge clk) disable iff (!nrst)
                                    miss_d ##2 data_rsp.err);

endmodule : dbsa_arbiter

`default_nettype wire

// >>> dbsa_mem_model.sv
// Behavioural one-cycle synchronous memory that answers one command port of the arbiter.
`timescale 1ns/1ps
`default_nettype none
module dbsa_mem_model #(
    parameter logic [7:0] ID = 8'h00   // Arbitrary tag placed in unwritten words.
) (
    input  wire logic                clk,
    input  wire dbsa_pkg::dbsa_mem_t cmd,
    output logic [31:0]              rdata
);
    logic [31:0] mem [logic [16:0]];
    logic [31:0] w;
    initial rdata = 32'h0;
    ////////////////////////////////////////////////////////////////////////////////
    // Unwritten words read as tag plus offset, so a wrong bank or offset shows at once.
    // Between reads the bus toggles instead of holding, so a late sample cannot pass.
    always @(posedge clk) begin
        w = mem.exists(cmd.addr) ? mem[cmd.addr] : {ID, 7'h0, cmd.addr};
        if (cmd.en && cmd.we) begin
            for (int i = 0; i < 4; i++) begin
                if (cmd.be[i]) w[8*i+:8] = cmd.wdata[8*i+:8];
            end
            mem[cmd.addr] = w;
        end
        rdata <= (cmd.en && !cmd.we) ? w : ~rdata;
    end
endmodule : dbsa_mem_model
`default_nettype wire

// >>> tb_dual_bank_sram_arbiter.sv
// Testbench for the dual-bank memory arbiter with memory models on its three command ports.
`timescale 1ns/1ps
`default_nettype none
module tb_dual_bank_sram_arbiter;
    localparam logic [7:0] RID = 8'h31;   // Arbitrary fill tags naming the answering memory.
    localparam logic [7:0] AID = 8'h32;
    localparam logic [7:0] BID = 8'h33;
    logic                clk = 1'h0;
    logic                nrst = 1'h0;
    dbsa_pkg::dbsa_req_t fr = '0;
    dbsa_pkg::dbsa_req_t dr = '0;
    logic                fg;
    logic                dg;
    dbsa_pkg::dbsa_rsp_t fs;
    dbsa_pkg::dbsa_rsp_t ds;
    dbsa_pkg::dbsa_rsp_t lf;
    dbsa_pkg::dbsa_rsp_t ld;
    dbsa_pkg::dbsa_mem_t rc;
    dbsa_pkg::dbsa_mem_t ac;
    dbsa_pkg::dbsa_mem_t bc;
    logic [31:0]         rrd;
    logic [31:0]         ard;
    logic [31:0]         brd;
    int                  failures = 0;
    int                  checks = 0;
    int                  cyc = 0;
    int                  gf = 0;
    int                  gd = 0;
    int                  nf = 0;
    int                  nd = 0;

    dbsa_arbiter dbsa_arbiter_i (.clk(clk), .nrst(nrst), .fetch_req(fr), .data_req(dr),
        .fetch_gnt(fg), .data_gnt(dg), .fetch_rsp(fs), .data_rsp(ds), .rom_cmd(rc),
        .bank0_cmd(ac), .bank1_cmd(bc), .rom_rdata(rrd), .bank0_rdata(ard), .bank1_rdata(brd));
    dbsa_mem_model #(.ID(RID)) dbsa_mem_model_rom_i (.clk(clk), .cmd(rc), .rdata(rrd));
    dbsa_mem_model #(.ID(AID)) dbsa_mem_model_b0_i (.clk(clk), .cmd(ac), .rdata(ard));
    dbsa_mem_model #(.ID(BID)) dbsa_mem_model_b1_i (.clk(clk), .cmd(bc), .rdata(brd));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock, cycle count, and a monitor sampling mid-cycle where everything has settled.
    initial forever #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge clk) begin
        if (fr.req && fg) gf = cyc;
        if (dr.req && dg) gd = cyc;
        if (fs.rvalid) begin
            chk(cyc, gf + dbsa_pkg::RSP_LAT, "fetch response latency");
            lf = fs;
            nf++;
        end
        if (ds.rvalid) begin
            chk(cyc, gd + dbsa_pkg::RSP_LAT, "data response latency");
            ld = ds;
            nd++;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    function automatic dbsa_pkg::dbsa_req_t mk(input logic we, input logic [31:0] a,
                                              input logic [31:0] w);
        mk = '{req: 1'h1, we: we, be: 4'hf, addr: a, wdata: w};
    endfunction : mk

    ////////////////////////////////////////////////////////////////////////////////
    // One transfer per port; a loser keeps its request up until granted, as the core would.
    task automatic xfer(input dbsa_pkg::dbsa_req_t f, input dbsa_pkg::dbsa_req_t d,
                        input logic [1:0] first, input logic [31:0] ef,
                        input logic [31:0] ed, input logic ee);
        logic [1:0] g;
        int         n;
        int         f0;
        int         d0;
        f0 = nf;
        d0 = nd;
        n = 0;
        @(posedge clk);
        fr <= f;
        dr <= d;
        @(negedge clk);
        g = {fg & f.req, dg & d.req};
        chk(g, first, "grants in the first cycle");
        while (g != {f.req, d.req} && n < 4) begin
            @(posedge clk);
            if (g[1]) fr.req <= 1'h0;
            if (g[0]) dr.req <= 1'h0;
            @(negedge clk);
            g = g | {fg & f.req, dg & d.req};
            n++;
        end
        chk(n, (first == {f.req, d.req}) ? 0 : 1, "cycles until the loser wins");
        @(posedge clk);
        fr <= '0;
        dr <= '0;
        repeat (3) @(negedge clk);
        chk(nf - f0, f.req, "fetch response count");
        chk(nd - d0, d.req, "data response count");
        if (f.req) chk(lf.err, ee, "fetch error flag");
        if (f.req) chk(lf.rdata, ef, "fetch read data");
        if (d.req && !d.we) chk(ld.err, ee, "data error flag");
        if (d.req && !d.we) chk(ld.rdata, ed, "data read data");
    endtask : xfer

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios: split banks, both conflicts at bank edges, boot ROM, holes, shared write.
    task automatic t_split;
        xfer(mk(0, 32'h0011_8004, 0), mk(0, 32'h0010_0008, 0), 2'h3,
             {BID, 24'h4}, {AID, 24'h8}, 0);
    endtask : t_split

    task automatic t_conf0;
        xfer(mk(0, 32'h0010_0000, 0), mk(0, 32'h0011_7ffc, 0), 2'h2,
             {AID, 24'h0}, {AID, 24'h1_7ffc}, 0);
    endtask : t_conf0

    task automatic t_conf1;
        xfer(mk(0, 32'h0011_8000, 0), mk(0, 32'h0011_fffc, 0), 2'h1,
             {BID, 24'h0}, {BID, 24'h7ffc}, 0);
    endtask : t_conf1

    task automatic t_rom;
        xfer(mk(0, 32'h0000_0000, 0), mk(0, 32'h0000_7ffc, 0), 2'h2,
             {RID, 24'h0}, {RID, 24'h7ffc}, 0);
        xfer(mk(0, 32'h0000_7ffc, 0), '0, 2'h2, {RID, 24'h7ffc}, 0, 0);
    endtask : t_rom

    task automatic t_holes;
        xfer(mk(0, 32'h000f_fffc, 0), mk(0, 32'h0012_0000, 0), 2'h3, 0, 0, 1);
        xfer(mk(0, 32'h0000_8000, 0), '0, 2'h2, 0, 0, 1);
    endtask : t_holes

    // A lone data write at the SRAM base, then a single-byte write over it, read by fetches.
    task automatic t_write;
        dbsa_pkg::dbsa_req_t w;
        w = mk(1, 32'h0010_0000, 32'h1234_5677);
        w.be = 4'h1;
        xfer('0, mk(1, 32'h0010_0000, 32'hc0de_5a11), 2'h1, 0, 0, 0);
        xfer(mk(0, 32'h0010_0000, 0), '0, 2'h2, 32'hc0de_5a11, 0, 0);
        xfer('0, w, 2'h1, 0, 0, 0);
        xfer(mk(0, 32'h0010_0000, 0), '0, 2'h2, 32'hc0de_5a77, 0, 0);
    endtask : t_write

    task automatic print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict

    // The full sequence takes well under 200 cycles, so 2000 only trips on a hang.
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        print_verdict;
    end

    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'h1;
        @(negedge clk);
        chk({fs.rvalid, ds.rvalid}, 2'h0, "responses idle after reset");
        t_split;
        t_conf0;
        t_conf1;
        t_rom;
        t_holes;
        t_write;
        print_verdict;
    end
endmodule : tb_dual_bank_sram_arbiter
`default_nettype wire
